// File: iosam_host_sw.sv
`default_nettype none
// Host sequence side: switch and relay contacts feeding the drive's input pins
module iosam_host_sw (
  input  wire logic       sys_clk_in,
  input  wire logic [6:0] sw_level_in,
  output logic      [6:0] pins_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Contacts settle at a clock edge; bounce is not modelled, so debouncing goes untested
  always_ff @(posedge sys_clk_in) begin
    pins_out <= sw_level_in;
  end
endmodule // iosam_host_sw
`default_nettype wire

// File: iosam_in_sel.sv
`default_nettype none
// One input function: pin pick, sense and forcing
module iosam_in_sel #(
  parameter bit HIGH_DEFAULT = 1'b0,
  parameter bit HIGH_PINS_ONLY = 1'b0
) (
  input  wire logic       sys_clk_in,
  input  wire logic       rst_b_in,
  input  wire logic [3:0] code_in,
  input  wire logic [6:0] pins_in,
  output logic            active_out
);
  logic [2:0] idx;
  logic       inv;
  logic       legal;
  logic       active_d;
  logic       active_q;

  always_comb begin
    inv   = (code_in >= iosam_pkg::SEL_INV_FIRST);
    idx   = inv ? 3'(code_in - iosam_pkg::SEL_INV_FIRST) : code_in[2:0];
    legal = 1'b1;
    if (HIGH_PINS_ONLY) begin
      legal = (code_in >= iosam_pkg::SEL_HI_FIRST && code_in <= iosam_pkg::SEL_HI_LAST) ||
              (code_in >= iosam_pkg::SEL_HI_INV_FIRST);
    end
    if (code_in == iosam_pkg::SEL_FORCE_ON) begin
      active_d = 1'b1;
    end else if (code_in == iosam_pkg::SEL_FORCE_OFF || !legal) begin
      // Unassignable pick reads as inactive, never as a random pin
      active_d = 1'b0;
    end else begin
      // Same pin may feed many functions, each with its own sense
      active_d = (pins_in[idx] == HIGH_DEFAULT) ^ inv;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      active_q <= 1'b0;
    end else begin
      active_q <= active_d;
    end
  end

  assign active_out = active_q;

  a_forced_on : assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    code_in == iosam_pkg::SEL_FORCE_ON |=> active_q)
    else $error("forced-on code not active");
  a_forced_off : assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    code_in == iosam_pkg::SEL_FORCE_OFF |=> !active_q)
    else $error("forced-off code active");
endmodule // iosam_in_sel
`default_nettype wire

// File: iosam_pkg.sv
`default_nettype none
package iosam_pkg;
  // Register byte offsets on the register bus
  localparam logic [4:0] REG_FWD_TRAVEL_SEL    = 5'h00;
  localparam logic [4:0] REG_TRAVEL_TORQUE_SEL = 5'h04;
  localparam logic [4:0] REG_OUT_ROUTE_A       = 5'h08;
  localparam logic [4:0] REG_OUT_ROUTE_B       = 5'h0c;
  localparam logic [4:0] REG_OUT_ROUTE_C       = 5'h10;
  localparam logic [4:0] REG_OPTION_SEL        = 5'h14;
  localparam logic [4:0] REG_OUT_POL_INV       = 5'h18;
  localparam logic [4:0] REG_PIN_STATUS        = 5'h1c;
  localparam int         ADDR_W                = 5;
  // Reset values: travel limits on pin codes 1 and 2, clamps and options forced off, no inversion
  localparam logic [15:0] RST_FWD_TRAVEL_SEL    = 16'h1000;
  localparam logic [15:0] RST_TRAVEL_TORQUE_SEL = 16'h8882;
  localparam logic [15:0] RST_OUT_ROUTE_A       = 16'h0000;
  localparam logic [15:0] RST_OUT_ROUTE_B       = 16'h0000;
  localparam logic [15:0] RST_OUT_ROUTE_C       = 16'h0000;
  localparam logic [15:0] RST_OPTION_SEL        = 16'h8888;
  localparam logic [15:0] RST_OUT_POL_INV       = 16'h0000;
  // Input selection codes
  localparam logic [3:0] SEL_PIN_LAST  = 4'h6;
  localparam logic [3:0] SEL_FORCE_ON  = 4'h7;
  localparam logic [3:0] SEL_FORCE_OFF = 4'h8;
  localparam logic [3:0] SEL_INV_FIRST = 4'h9;
  localparam logic [3:0] SEL_HI_FIRST  = 4'h4;
  localparam logic [3:0] SEL_HI_LAST   = 4'h6;
  localparam logic [3:0] SEL_HI_INV_FIRST = 4'hd;
  // Output route codes
  localparam logic [3:0] ROUTE_NONE = 4'h0;
  localparam int         NUM_PINS   = 7;
  localparam int         NUM_OUTF   = 9;
  localparam int         NUM_PAIRS  = 3;
  localparam logic [1:0] RESP_OKAY  = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : iosam_pkg
`default_nettype wire

// File: iosam_top.sv
`default_nettype none
module iosam_top (
  input  wire logic        sys_clk_in,
  input  wire logic        rst_b_in,
  // AXI4-Lite slave
  input  wire logic [4:0]  s_axi_awaddr_in,
  input  wire logic        s_axi_awvalid_in,
  output logic             s_axi_awready_out,
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  input  wire logic        s_axi_wvalid_in,
  output logic             s_axi_wready_out,
  output logic [1:0]       s_axi_bresp_out,
  output logic             s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  input  wire logic [4:0]  s_axi_araddr_in,
  input  wire logic        s_axi_arvalid_in,
  output logic             s_axi_arready_out,
  output logic [31:0]      s_axi_rdata_out,
  output logic [1:0]       s_axi_rresp_out,
  output logic             s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in,
  // Input pins in order 13,7,8,9,10,11,12
  input  wire logic [6:0]  in_pins_in,
  // Internal status: position_done, speed_match, motor_turning, drive_ready,
  // torque_limited, speed_limited, brake_release, warning, near_position
  input  wire logic [8:0]  status_in,
  input  wire logic [8:0]  status_valid_in,
  output logic             fwd_travel_limit_out,
  output logic             rev_travel_limit_out,
  output logic             fwd_torque_clamp_req_out,
  output logic             rev_torque_clamp_req_out,
  output logic [3:0]       option_in_out,
  // Pairs 1/2, 23/24, 25/26
  output logic [2:0]       out_pairs_out
);
  logic [15:0] fwd_sel_q;
  logic [15:0] tt_sel_q;
  logic [15:0] route_a_q;
  logic [15:0] route_b_q;
  logic [15:0] route_c_q;
  logic [15:0] opt_sel_q;
  logic [15:0] pol_inv_q;
  logic        aw_held_q;
  logic        w_held_q;
  logic [4:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        rvalid_q;
  logic [1:0]  rresp_q;
  logic [31:0] rdata_q;
  logic        do_write;
  logic        wr_hit;
  logic [35:0] route_codes;
  logic [2:0]  pair_or;
  logic [2:0]  pairs_d;
  logic [2:0]  pairs_q;

  function automatic logic reg_known(input logic [4:0] a);
    reg_known = (a == iosam_pkg::REG_FWD_TRAVEL_SEL) ||
                (a == iosam_pkg::REG_TRAVEL_TORQUE_SEL) ||
                (a == iosam_pkg::REG_OUT_ROUTE_A) || (a == iosam_pkg::REG_OUT_ROUTE_B) ||
                (a == iosam_pkg::REG_OUT_ROUTE_C) || (a == iosam_pkg::REG_OPTION_SEL) ||
                (a == iosam_pkg::REG_OUT_POL_INV) || (a == iosam_pkg::REG_PIN_STATUS);
  endfunction

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  // Write side: address and data taken in either order
  assign s_axi_awready_out = !aw_held_q && !bvalid_q;
  assign s_axi_wready_out  = !w_held_q && !bvalid_q;
  assign do_write          = aw_held_q && w_held_q && !bvalid_q;
  assign wr_hit            = reg_known(awaddr_q) && awaddr_q != iosam_pkg::REG_PIN_STATUS;

  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      aw_held_q <= 1'b0;
      awaddr_q  <= 5'h00;
    end else if (s_axi_awvalid_in && s_axi_awready_out) begin
      aw_held_q <= 1'b1;
      awaddr_q  <= s_axi_awaddr_in;
    end else if (do_write) begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      w_held_q <= 1'b0;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
    end else if (s_axi_wvalid_in && s_axi_wready_out) begin
      w_held_q <= 1'b1;
      wdata_q  <= s_axi_wdata_in;
      wstrb_q  <= s_axi_wstrb_in;
    end else if (do_write) begin
      w_held_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      bvalid_q <= 1'b0;
      bresp_q  <= iosam_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_hit ? iosam_pkg::RESP_OKAY : iosam_pkg::RESP_SLVERR;
    end else if (s_axi_bready_in) begin
      bvalid_q <= 1'b0;
    end
  end

  assign s_axi_bvalid_out = bvalid_q;
  assign s_axi_bresp_out  = bresp_q;

  // Settings registers; all take effect on the next edge
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      fwd_sel_q <= iosam_pkg::RST_FWD_TRAVEL_SEL;
      tt_sel_q  <= iosam_pkg::RST_TRAVEL_TORQUE_SEL;
      route_a_q <= iosam_pkg::RST_OUT_ROUTE_A;
      route_b_q <= iosam_pkg::RST_OUT_ROUTE_B;
      route_c_q <= iosam_pkg::RST_OUT_ROUTE_C;
      opt_sel_q <= iosam_pkg::RST_OPTION_SEL;
      pol_inv_q <= iosam_pkg::RST_OUT_POL_INV;
    end else if (do_write) begin
      unique case (awaddr_q)
        iosam_pkg::REG_FWD_TRAVEL_SEL:    fwd_sel_q <= merge(fwd_sel_q, wdata_q, wstrb_q);
        iosam_pkg::REG_TRAVEL_TORQUE_SEL: tt_sel_q  <= merge(tt_sel_q, wdata_q, wstrb_q);
        iosam_pkg::REG_OUT_ROUTE_A:       route_a_q <= merge(route_a_q, wdata_q, wstrb_q);
        iosam_pkg::REG_OUT_ROUTE_B:       route_b_q <= merge(route_b_q, wdata_q, wstrb_q);
        iosam_pkg::REG_OUT_ROUTE_C:       route_c_q <= merge(route_c_q, wdata_q, wstrb_q);
        iosam_pkg::REG_OPTION_SEL:        opt_sel_q <= merge(opt_sel_q, wdata_q, wstrb_q);
        iosam_pkg::REG_OUT_POL_INV:       pol_inv_q <= merge(pol_inv_q, wdata_q, wstrb_q);
        default: ;
      endcase
    end
  end

  // Read side: one read at a time, answer one cycle after address taken
  assign s_axi_arready_out = !rvalid_q;

  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      rvalid_q <= 1'b0;
      rresp_q  <= iosam_pkg::RESP_OKAY;
      rdata_q  <= 32'h0000_0000;
    end else if (s_axi_arvalid_in && s_axi_arready_out) begin
      rvalid_q <= 1'b1;
      rresp_q  <= reg_known(s_axi_araddr_in) ? iosam_pkg::RESP_OKAY : iosam_pkg::RESP_SLVERR;
      unique case (s_axi_araddr_in)
        iosam_pkg::REG_FWD_TRAVEL_SEL:    rdata_q <= {16'h0000, fwd_sel_q};
        iosam_pkg::REG_TRAVEL_TORQUE_SEL: rdata_q <= {16'h0000, tt_sel_q};
        iosam_pkg::REG_OUT_ROUTE_A:       rdata_q <= {16'h0000, route_a_q};
        iosam_pkg::REG_OUT_ROUTE_B:       rdata_q <= {16'h0000, route_b_q};
        iosam_pkg::REG_OUT_ROUTE_C:       rdata_q <= {16'h0000, route_c_q};
        iosam_pkg::REG_OPTION_SEL:        rdata_q <= {16'h0000, opt_sel_q};
        iosam_pkg::REG_OUT_POL_INV:       rdata_q <= {16'h0000, pol_inv_q};
        iosam_pkg::REG_PIN_STATUS:        rdata_q <= {16'h0000, pairs_q, 5'h00,
                                                      option_in_out, fwd_travel_limit_out,
                                                      rev_travel_limit_out,
                                                      fwd_torque_clamp_req_out,
                                                      rev_torque_clamp_req_out};
        default:                          rdata_q <= 32'h0000_0000;
      endcase
    end else if (s_axi_rready_in) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_rvalid_out = rvalid_q;
  assign s_axi_rresp_out  = rresp_q;
  assign s_axi_rdata_out  = rdata_q;

  // Input functions; travel limits keep active-high default since an
  // inverted sense would let a broken wire release motion
  iosam_in_sel #(.HIGH_DEFAULT(1'b1), .HIGH_PINS_ONLY(1'b0)) u_fwd_travel (
    .sys_clk_in (sys_clk_in),
    .rst_b_in   (rst_b_in),
    .code_in    (fwd_sel_q[15:12]),
    .pins_in    (in_pins_in),
    .active_out (fwd_travel_limit_out)
  );
  iosam_in_sel #(.HIGH_DEFAULT(1'b1), .HIGH_PINS_ONLY(1'b0)) u_rev_travel (
    .sys_clk_in (sys_clk_in),
    .rst_b_in   (rst_b_in),
    .code_in    (tt_sel_q[3:0]),
    .pins_in    (in_pins_in),
    .active_out (rev_travel_limit_out)
  );
  iosam_in_sel #(.HIGH_DEFAULT(1'b0), .HIGH_PINS_ONLY(1'b0)) u_fwd_clamp (
    .sys_clk_in (sys_clk_in),
    .rst_b_in   (rst_b_in),
    .code_in    (tt_sel_q[11:8]),
    .pins_in    (in_pins_in),
    .active_out (fwd_torque_clamp_req_out)
  );
  iosam_in_sel #(.HIGH_DEFAULT(1'b0), .HIGH_PINS_ONLY(1'b0)) u_rev_clamp (
    .sys_clk_in (sys_clk_in),
    .rst_b_in   (rst_b_in),
    .code_in    (tt_sel_q[15:12]),
    .pins_in    (in_pins_in),
    .active_out (rev_torque_clamp_req_out)
  );

  // Option 3 takes any pin; options 4-6 only the upper three
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_opt
      iosam_in_sel #(.HIGH_DEFAULT(1'b0), .HIGH_PINS_ONLY(g != 0)) u_opt (
        .sys_clk_in (sys_clk_in),
        .rst_b_in   (rst_b_in),
        .code_in    (opt_sel_q[4*g+3:4*g]),
        .pins_in    (in_pins_in),
        .active_out (option_in_out[g])
      );
    end
  endgenerate

  // Output routing: route A, then B, then C digit 0
  assign route_codes = {route_c_q[3:0], route_b_q, route_a_q};

  always_comb begin
    pair_or = 3'h0;
    for (int f = 0; f < iosam_pkg::NUM_OUTF; f++) begin
      for (int p = 0; p < iosam_pkg::NUM_PAIRS; p++) begin
        if (route_codes[4*f +: 4] == 4'(p + 1) && status_valid_in[f]) begin
          pair_or[p] = pair_or[p] | status_in[f];
        end
      end
    end
    pairs_d = pair_or ^ pol_inv_q[2:0];
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      pairs_q <= 3'h0;
    end else begin
      pairs_q <= pairs_d;
    end
  end

  assign out_pairs_out = pairs_q;

  sequence s_write_done;
    do_write;
  endsequence
  sequence s_resp_up;
    s_axi_bvalid_out;
  endsequence
  sequence s_read_taken;
    s_axi_arvalid_in && s_axi_arready_out;
  endsequence
  sequence s_read_up;
    s_axi_rvalid_out;
  endsequence

  // Bus answers: a taken read is answered on the next edge, a write on the edge after address and data are both held
  a_write_resp : assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    s_write_done |=> s_resp_up)
    else $error("write response missing");
  a_read_resp : assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    s_read_taken |=> s_read_up)
    else $error("read response missing");
  // A master may hold ready low a while; the answer must not slip meanwhile
  a_bresp_hold : assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
    else $error("write response dropped early");
  a_rdata_hold : assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out &&
      $stable(s_axi_rdata_out) && $stable(s_axi_rresp_out))
    else $error("read answer changed while pending");
  // Status word is read-only, so a write to it is refused
  a_status_ro : assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    do_write && awaddr_q == iosam_pkg::REG_PIN_STATUS
      |=> s_axi_bresp_out == iosam_pkg::RESP_SLVERR)
    else $error("status write not refused");

  // Output pairs
  a_pair0_inv : assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    1'b1 |=> out_pairs_out[0] == ($past(pair_or[0]) ^ $past(pol_inv_q[0])))
    else $error("pair 1/2 level wrong");
  a_pair1_inv : assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    1'b1 |=> out_pairs_out[1] == ($past(pair_or[1]) ^ $past(pol_inv_q[1])))
    else $error("pair 23/24 level wrong");
  a_pair2_inv : assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    1'b1 |=> out_pairs_out[2] == ($past(pair_or[2]) ^ $past(pol_inv_q[2])))
    else $error("pair 25/26 level wrong");
  a_unrouted_off : assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    (route_a_q == 16'h0000 && route_b_q == 16'h0000 && route_c_q[3:0] == 4'h0)
      |=> out_pairs_out == $past(pol_inv_q[2:0]))
    else $error("unrouted function drove a pair");
  a_invalid_none : assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    status_valid_in == 9'h000 |=> out_pairs_out == $past(pol_inv_q[2:0]))
    else $error("invalid function contributed");
  // Two functions on one pair: either alone must drive it
  a_pair_or : assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    route_a_q[7:0] == 8'h11 && status_valid_in[1:0] == 2'h3 && !pol_inv_q[0] &&
      (status_in[0] || status_in[1]) |=> out_pairs_out[0])
    else $error("pair 1/2 missed an ORed function");

  // Input functions
  a_fwd_pin13 : assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    fwd_sel_q[15:12] == 4'h0 |=> fwd_travel_limit_out == $past(in_pins_in[0]))
    else $error("travel limit sense wrong");
  a_rev_pin13 : assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    tt_sel_q[3:0] == 4'h0 |=> rev_travel_limit_out == $past(in_pins_in[0]))
    else $error("reverse travel limit sense wrong");
  a_clamp_inv : assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    tt_sel_q[11:8] == 4'h9 |=> fwd_torque_clamp_req_out == $past(in_pins_in[0]))
    else $error("clamp inverted sense wrong");
  a_rclamp_low : assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    tt_sel_q[15:12] == 4'h0 |=> rev_torque_clamp_req_out == !$past(in_pins_in[0]))
    else $error("reverse clamp default sense wrong");
  a_opt3_any : assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    opt_sel_q[3:0] == 4'h3 |=> option_in_out[0] == !$past(in_pins_in[3]))
    else $error("option 3 pick wrong");
  a_opt4_low : assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    opt_sel_q[7:4] == 4'h0 |=> !option_in_out[1])
    else $error("option 4 took a barred pin");
  a_opt6_hi : assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    opt_sel_q[15:12] == 4'hf |=> option_in_out[3] == $past(in_pins_in[6]))
    else $error("option 6 inverted pick wrong");
  a_shared_pin : assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    fwd_sel_q[15:12] == 4'h0 && tt_sel_q[3:0] == 4'h0
      |=> fwd_travel_limit_out == rev_travel_limit_out)
    else $error("shared pin reached functions unequally");
endmodule // iosam_top
`default_nettype wire

// File: tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst_b, awv, awr, wv, wr, bv, brdy, arv, arr, rv, rrdy;
  logic        fwd_t, rev_t, fwd_c, rev_c;
  logic [4:0]  awa, ara;
  logic [31:0] wd, rd;
  logic [3:0]  ws, opt;
  logic [1:0]  br, rr;
  logic [6:0]  sw, pins;
  logic [8:0]  st, stv;
  logic [2:0]  pairs;
  int          errors = 0;
  int          total_checks = 0;
  int          cycles = 0;

  iosam_host_sw i_iosam_host_sw (.sys_clk_in(clk), .sw_level_in(sw), .pins_out(pins));

  iosam_top i_iosam_top (
    .sys_clk_in(clk), .rst_b_in(rst_b),
    .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv), .s_axi_awready_out(awr),
    .s_axi_wdata_in(wd), .s_axi_wstrb_in(ws), .s_axi_wvalid_in(wv), .s_axi_wready_out(wr),
    .s_axi_bresp_out(br), .s_axi_bvalid_out(bv), .s_axi_bready_in(brdy),
    .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
    .s_axi_rdata_out(rd), .s_axi_rresp_out(rr), .s_axi_rvalid_out(rv),
    .s_axi_rready_in(rrdy), .in_pins_in(pins), .status_in(st), .status_valid_in(stv),
    .fwd_travel_limit_out(fwd_t), .rev_travel_limit_out(rev_t),
    .fwd_torque_clamp_req_out(fwd_c), .rev_torque_clamp_req_out(rev_c),
    .option_in_out(opt), .out_pairs_out(pairs)
  );

  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end

  // Whole run needs about 2600 cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      errors++;
      conclude();
    end
  end

  task automatic conclude();
    $display("Checks %0d, errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Address and data offered together; each released only when its own ready is seen
  task automatic wr_reg(input logic [4:0] a, input logic [31:0] d, input logic [3:0] s,
                        input logic [1:0] er);
    awa <= a;
    @(posedge clk);
    awa <= a;
    awv <= 1'h1;
    wd <= d;
    ws <= s;
    wv <= 1'h1;
    brdy <= 1'h1;
    do begin
      @(posedge clk);
      if (awv && awr)
        awv <= 1'h0;
      if (wv && wr)
        wv <= 1'h0;
    end while ((awv && !awr) || (wv && !wr));
    do @(posedge clk); while (!bv);
    brdy <= 1'h0;
    check(32'(br), 32'(er), "write response");
  endtask

  task automatic wr_ok(input logic [4:0] a, input logic [15:0] d);
    wr_reg(a, {16'h0, d}, 4'hf, iosam_pkg::RESP_OKAY);
  endtask

  task automatic rd_reg(input logic [4:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge clk);
    ara <= a;
    arv <= 1'h1;
    rrdy <= 1'h1;
    do @(posedge clk); while (!arr);
    arv <= 1'h0;
    do @(posedge clk); while (!rv);
    rrdy <= 1'h0;
    check(rd, ed, "read data");
    check(32'(rr), 32'(er), "read response");
  endtask

  task automatic rd_ok(input logic [4:0] a, input logic [15:0] d);
    rd_reg(a, {16'h0, d}, iosam_pkg::RESP_OKAY);
  endtask

  // Pin path adds one edge in the host model and one in the block
  task automatic settle();
    repeat (4) @(posedge clk);
  endtask

  function automatic logic ex(input logic [3:0] c, input logic [6:0] p, input logic h,
                              input logic o);
    if (c == 4'h7)
      return 1'h1;
    if (c == 4'h8)
      return 1'h0;
    if (o && !((c >= 4'h4 && c <= 4'h6) || c >= 4'hd))
      return 1'h0;
    if (c <= 4'h6)
      return h ? p[c] : ~p[c];
    return h ? ~p[c - 4'h9] : p[c - 4'h9];
  endfunction

  task automatic reg_scan();
    rd_ok(iosam_pkg::REG_FWD_TRAVEL_SEL, iosam_pkg::RST_FWD_TRAVEL_SEL);
    rd_ok(iosam_pkg::REG_TRAVEL_TORQUE_SEL, iosam_pkg::RST_TRAVEL_TORQUE_SEL);
    rd_ok(iosam_pkg::REG_OUT_ROUTE_A, iosam_pkg::RST_OUT_ROUTE_A);
    rd_ok(iosam_pkg::REG_OUT_ROUTE_B, iosam_pkg::RST_OUT_ROUTE_B);
    rd_ok(iosam_pkg::REG_OUT_ROUTE_C, iosam_pkg::RST_OUT_ROUTE_C);
    rd_ok(iosam_pkg::REG_OPTION_SEL, iosam_pkg::RST_OPTION_SEL);
    rd_ok(iosam_pkg::REG_OUT_POL_INV, iosam_pkg::RST_OUT_POL_INV);
    rd_ok(iosam_pkg::REG_PIN_STATUS, 16'h0000);
    wr_reg(iosam_pkg::REG_PIN_STATUS, 32'h0000ffff, 4'hf, iosam_pkg::RESP_SLVERR);
    rd_ok(iosam_pkg::REG_PIN_STATUS, 16'h0000);
    wr_reg(iosam_pkg::REG_OUT_ROUTE_A, 32'hffff1234, 4'h1, iosam_pkg::RESP_OKAY);
    rd_ok(iosam_pkg::REG_OUT_ROUTE_A, 16'h0034);
    rd_reg(5'h02, 32'h0000_0000, iosam_pkg::RESP_SLVERR);
    wr_reg(5'h02, 32'h0000ffff, 4'hf, iosam_pkg::RESP_SLVERR);
    rd_ok(iosam_pkg::REG_FWD_TRAVEL_SEL, iosam_pkg::RST_FWD_TRAVEL_SEL);
  endtask

  // Every function shares one code, so the picked pin feeds all of them at once; options 4-6 refuse the lower four pins
  task automatic in_scan();
    logic [3:0] c;
    logic [6:0] p;
    logic [7:0] e;
    for (int k = 0; k < 16; k++) begin
      c = 4'(k);
      wr_ok(iosam_pkg::REG_FWD_TRAVEL_SEL, {c, 12'h000});
      wr_ok(iosam_pkg::REG_TRAVEL_TORQUE_SEL, {c, c, 4'h0, c});
      wr_ok(iosam_pkg::REG_OPTION_SEL, {c, c, c, c});
      for (int j = 0; j < 14; j++) begin
        p = (j < 7) ? 7'(1 << j) : ~7'(1 << (j - 7));
        @(posedge clk);
        sw <= p;
        settle();
        e = {ex(c, p, 1'h1, 1'h0), ex(c, p, 1'h1, 1'h0), ex(c, p, 1'h0, 1'h0),
             ex(c, p, 1'h0, 1'h0), ex(c, p, 1'h0, 1'h1), ex(c, p, 1'h0, 1'h1),
             ex(c, p, 1'h0, 1'h1), ex(c, p, 1'h0, 1'h0)};
        check(32'({fwd_t, rev_t, fwd_c, rev_c, opt}), 32'(e), "inputs");
      end
      rd_ok(iosam_pkg::REG_PIN_STATUS, {8'h00, e[3:0], e[7:4]});
    end
  endtask

  task automatic out_case(input logic [35:0] r, input logic [8:0] s, input logic [8:0] v,
                          input logic [2:0] inv);
    logic [2:0] e;
    wr_ok(iosam_pkg::REG_OUT_ROUTE_A, r[15:0]);
    wr_ok(iosam_pkg::REG_OUT_ROUTE_B, r[31:16]);
    wr_ok(iosam_pkg::REG_OUT_ROUTE_C, {12'h000, r[35:32]});
    wr_ok(iosam_pkg::REG_OUT_POL_INV, {13'h0000, inv});
    @(posedge clk);
    st <= s;
    stv <= v;
    settle();
    e = inv;
    for (int f = 0; f < 9; f++) begin
      for (int q = 0; q < 3; q++) begin
        if (r[4 * f +: 4] == 4'(q + 1) && s[f] && v[f])
          e[q] = ~inv[q];
      end
    end
    check(32'(pairs), 32'(e), "output pairs");
  endtask

  task automatic out_scan();
    for (int f = 0; f < 9; f++) begin
      for (int k = 0; k < 5; k++)
        out_case(36'(k) << (4 * f), 9'(1 << f), 9'h1ff, 3'h0);
    end
    for (int i = 0; i < 8; i++)
      out_case(36'h000000000, 9'h000, 9'h1ff, 3'(i));
    out_case(36'h111111111, 9'h100, 9'h1ff, 3'h0);
    out_case(36'h111111111, 9'h000, 9'h1ff, 3'h0);
    out_case(36'h000000011, 9'h002, 9'h003, 3'h0);
    out_case(36'h321321321, 9'h1ff, 9'h000, 3'h0);
    out_case(36'h321321321, 9'h0c0, 9'h080, 3'h5);
    rd_ok(iosam_pkg::REG_OUT_POL_INV, 16'h0005);
  endtask

  initial begin
    rst_b = 1'h0;
    {awv, wv, brdy, arv, rrdy} = 5'h00;
    awa = 5'h00;
    ara = 5'h00;
    wd = 32'h0;
    ws = 4'h0;
    sw = 7'h00;
    st = 9'h000;
    stv = 9'h000;
    repeat (2) @(posedge clk);
    rst_b <= 1'h1;
    reg_scan();
    in_scan();
    out_scan();
    conclude();
  end
endmodule // tb
`default_nettype wire
